/* design/tcc_pkg.sv */
// Constants, types and register map of the 16-bit capture/compare timer
package tcc_pkg;
	// Register byte addresses
	localparam logic [31:0] OFF_MODE = 32'h0000_0000;
	localparam logic [31:0] OFF_ROLE = 32'h0000_0004;
	localparam logic [31:0] OFF_OUTC = 32'h0000_0008;
	localparam logic [31:0] OFF_PRESC = 32'h0000_000C;
	localparam logic [31:0] OFF_CNT = 32'h0000_0010;
	localparam logic [31:0] OFF_FIRST = 32'h0000_0014;
	localparam logic [31:0] OFF_SECOND = 32'h0000_0018;
	// Field positions
	localparam int MODE_WRAP_BIT = 0;
	localparam int MODE_EDGE_OUT_BIT = 1;
	localparam int MODE_SEL_LSB = 2;
	localparam int ROLE_FIRST_CAP_BIT = 0;
	localparam int ROLE_REVERSE_BIT = 1;
	localparam int ROLE_SECOND_CAP_BIT = 2;
	localparam int OUTC_ENABLE_BIT = 0;
	localparam int PRESC_CLK_LSB = 0;
	localparam int PRESC_PRIM_LSB = 4;
	localparam int PRESC_SEC_LSB = 6;
	// Counter values
	localparam logic [15:0] CNT_ZERO = 16'h0000;
	localparam logic [15:0] CNT_ONE = 16'h0001;
	localparam logic [15:0] CNT_MAX = 16'hFFFF;
	// Prescaler terminal counts per clock select
	localparam logic [7:0] PRESC_TERM0 = 8'h00;
	localparam logic [7:0] PRESC_TERM1 = 8'h03;
	localparam logic [7:0] PRESC_TERM2 = 8'h0F;
	localparam logic [7:0] PRESC_TERM3 = 8'hFF;
	// Bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Counter modes
	typedef enum logic [1:0] {
		TCC_MODE_STOP = 2'h0,
		TCC_MODE_FREE = 2'h1,
		TCC_MODE_EDGE_CLR = 2'h2,
		TCC_MODE_PPG = 2'h3
	} tcc_mode_t;
	// Valid edge selections
	localparam logic [1:0] EDGE_FALL = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_NONE = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;
	// Edge detector state
	typedef struct packed {
		logic s1, s2, s3, rise, fall;
	} tcc_edge_st_t;
	// Prescaler state
	typedef struct packed {
		logic [7:0] div;
		logic tick;
	} tcc_presc_st_t;
	// Timer and bus state
	typedef struct packed {
		logic have_aw, have_w, aw_rdy, w_rdy, ar_rdy, bvalid, rvalid;
		logic [31:0] aw_addr, w_data, rdata;
		logic [3:0] w_strb;
		logic [1:0] bresp, rresp, mode_sel;
		logic edge_out, wrap, out_en, pin, ev1, ev2;
		logic [2:0] role;
		logic [7:0] presc;
		logic [15:0] cnt, first, second;
	} tcc_state_t;
endpackage

/* design/tcc_edge.sv */
// Pin synchroniser with rising and falling edge pulses
`timescale 1ns/1ps
`default_nettype none
module tcc_edge
	import tcc_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic resetn_in,
	// Pin and edges
	input wire logic pin_in,
	output logic rise_out,
	output logic fall_out
);
	tcc_edge_st_t s, n;

	// Two-stage sync, third stage for history
	always_comb begin
		n = s;
		n.s1 = pin_in;
		n.s2 = s.s1;
		n.s3 = s.s2;
		n.rise = s.s2 & ~s.s3;
		n.fall = ~s.s2 & s.s3;
	end

	// State register
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign rise_out = s.rise;
	assign fall_out = s.fall;
endmodule // tcc_edge
`default_nettype wire

/* design/tcc_presc.sv */
// Count clock prescaler producing one-cycle ticks
`timescale 1ns/1ps
`default_nettype none
module tcc_presc
	import tcc_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic resetn_in,
	// Control
	input wire logic run_in,
	input wire logic restart_in,
	input wire logic [1:0] sel_in,
	// Count clock
	output logic tick_out
);
	tcc_presc_st_t s, n;
	logic [7:0] term;

	// Divider terminal count
	always_comb begin
		unique case (sel_in)
			2'h0: term = PRESC_TERM0;
			2'h1: term = PRESC_TERM1;
			2'h2: term = PRESC_TERM2;
			2'h3: term = PRESC_TERM3;
		endcase
	end

	// Divider restarts when stopped or cleared
	always_comb begin
		n = s;
		n.tick = 1'b0;
		if (!run_in || restart_in) begin
			n.div = '0;
		end else if (s.div >= term) begin
			n.div = '0;
			n.tick = 1'b1;
		end else begin
			n.div = s.div + 8'h01;
		end
	end

	// State register
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign tick_out = s.tick;
endmodule // tcc_presc
`default_nettype wire

/* design/tcc_timer.sv */
// 16-bit capture/compare timer with pulse generator and AXI4-Lite registers
//
// Decided for this implementation: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module tcc_timer
	import tcc_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic resetn_in,
	// AXI4-Lite write address
	input wire logic [31:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	// AXI4-Lite read address
	input wire logic [31:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	// Capture pins
	input wire logic primary_capture_input_in,
	input wire logic secondary_capture_input_in,
	// Timer output and events
	output logic toggle_output_pin_out,
	output logic first_match_event_out,
	output logic second_match_event_out
);
	tcc_state_t s, n;
	tcc_mode_t mode;
	logic prim_rise, prim_fall, sec_rise, sec_fall, tick;
	logic prim_v, sec_v, prim_opp, run, m1, m2, first_cap, second_cap, rev;
	logic edge_clr, edge_tog, wcommit;
	logic [1:0] prim_sel, sec_sel;

	// Merge byte lanes of a 16-bit register
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] strb);
		merge16 = old;
		if (strb[0]) begin
			merge16[7:0] = d[7:0];
		end
		if (strb[1]) begin
			merge16[15:8] = d[15:8];
		end
	endfunction

	// Valid edge from selection
	function automatic logic valid_edge(input logic [1:0] sel, input logic r, input logic f);
		unique case (sel)
			EDGE_FALL: valid_edge = f;
			EDGE_RISE: valid_edge = r;
			EDGE_NONE: valid_edge = 1'b0;
			EDGE_BOTH: valid_edge = r | f;
		endcase
	endfunction

	// Pin synchronisers
	tcc_edge u_prim (
		.clk_in(clk_in),
		.resetn_in(resetn_in),
		.pin_in(primary_capture_input_in),
		.rise_out(prim_rise),
		.fall_out(prim_fall)
	);
	tcc_edge u_sec (
		.clk_in(clk_in),
		.resetn_in(resetn_in),
		.pin_in(secondary_capture_input_in),
		.rise_out(sec_rise),
		.fall_out(sec_fall)
	);

	// Count clock
	tcc_presc u_presc (
		.clk_in(clk_in),
		.resetn_in(resetn_in),
		.run_in(run),
		.restart_in(edge_clr),
		.sel_in(s.presc[PRESC_CLK_LSB +: 2]),
		.tick_out(tick)
	);

	// Decoded controls and qualified events
	assign mode = tcc_mode_t'(s.mode_sel);
	assign run = (mode != TCC_MODE_STOP);
	assign prim_sel = s.presc[PRESC_PRIM_LSB +: 2];
	assign sec_sel = s.presc[PRESC_SEC_LSB +: 2];
	assign first_cap = s.role[ROLE_FIRST_CAP_BIT];
	assign second_cap = s.role[ROLE_SECOND_CAP_BIT];
	assign rev = s.role[ROLE_REVERSE_BIT];
	assign prim_v = run && valid_edge(prim_sel, prim_rise, prim_fall);
	assign sec_v = run && valid_edge(sec_sel, sec_rise, sec_fall);
	// Opposite phase of the primary valid edge
	assign prim_opp = run && valid_edge(prim_sel, prim_fall, prim_rise);
	// Compare matches sampled at the count clock
	assign m1 = run && tick && !first_cap && (s.cnt == s.first);
	assign m2 = run && tick && !second_cap && (s.cnt == s.second);
	assign edge_clr = (mode == TCC_MODE_EDGE_CLR) && prim_v;
	assign edge_tog = s.edge_out && prim_v && (mode != TCC_MODE_PPG);
	assign wcommit = s.have_aw && s.have_w;

	// Next state: bus slave first, timer hardware after so it wins
	always_comb begin
		n = s;
		n.ev1 = 1'b0;
		n.ev2 = 1'b0;
		// Write address and data taken independently
		if (s_axi_awvalid_in && s.aw_rdy) begin
			n.have_aw = 1'b1;
			n.aw_addr = s_axi_awaddr_in;
		end
		if (s_axi_wvalid_in && s.w_rdy) begin
			n.have_w = 1'b1;
			n.w_data = s_axi_wdata_in;
			n.w_strb = s_axi_wstrb_in;
		end
		if (s.bvalid && s_axi_bready_in) begin
			n.bvalid = 1'b0;
		end
		// Register write once both halves are held
		if (wcommit) begin
			n.have_aw = 1'b0;
			n.have_w = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = RESP_OKAY;
			unique case (s.aw_addr)
				OFF_MODE: if (s.w_strb[0]) begin
					n.mode_sel = s.w_data[MODE_SEL_LSB +: 2];
					n.edge_out = s.w_data[MODE_EDGE_OUT_BIT];
					if (!s.w_data[MODE_WRAP_BIT]) begin
						n.wrap = 1'b0;
					end
				end
				OFF_ROLE: if (s.w_strb[0]) begin
					n.role = s.w_data[2:0];
				end
				OFF_OUTC: if (s.w_strb[0]) begin
					n.out_en = s.w_data[OUTC_ENABLE_BIT];
				end
				OFF_PRESC: if (s.w_strb[0]) begin
					n.presc = s.w_data[7:0];
				end
				OFF_CNT: ;
				OFF_FIRST: n.first = merge16(s.first, s.w_data, s.w_strb);
				OFF_SECOND: n.second = merge16(s.second, s.w_data, s.w_strb);
				default: n.bresp = RESP_SLVERR;
			endcase
		end
		n.aw_rdy = !n.have_aw && !n.bvalid;
		n.w_rdy = !n.have_w && !n.bvalid;
		// Read: data captured at the address handshake
		if (s.rvalid && s_axi_rready_in) begin
			n.rvalid = 1'b0;
		end
		if (s_axi_arvalid_in && s.ar_rdy) begin
			n.rvalid = 1'b1;
			n.rresp = RESP_OKAY;
			unique case (s_axi_araddr_in)
				OFF_MODE: n.rdata = {28'h000_0000, s.mode_sel, s.edge_out, s.wrap};
				OFF_ROLE: n.rdata = {29'h0000_0000, s.role};
				OFF_OUTC: n.rdata = {31'h0000_0000, s.out_en};
				OFF_PRESC: n.rdata = {24'h00_0000, s.presc};
				OFF_CNT: n.rdata = {16'h0000, s.cnt};
				OFF_FIRST: n.rdata = {16'h0000, s.first};
				OFF_SECOND: n.rdata = {16'h0000, s.second};
				default: begin
					n.rdata = 32'h0000_0000;
					n.rresp = RESP_SLVERR;
				end
			endcase
		end
		n.ar_rdy = !n.rvalid;
		// Counter
		if (!run) begin
			n.cnt = CNT_ZERO;
		end else if (edge_clr) begin
			n.cnt = CNT_ZERO;
		end else if (tick) begin
			if (mode == TCC_MODE_PPG && s.cnt == s.first) begin
				n.cnt = CNT_ZERO;
			end else if (s.cnt == CNT_MAX) begin
				n.cnt = CNT_ZERO;
				n.wrap = 1'b1;
			end else begin
				n.cnt = s.cnt + CNT_ONE;
			end
		end
		// Compare events
		if (m1) begin
			n.ev1 = 1'b1;
		end
		if (m2) begin
			n.ev2 = 1'b1;
		end
		// Second register captures on primary edges only
		if (second_cap && prim_v) begin
			n.second = s.cnt;
			n.ev2 = 1'b1;
		end
		// First register capture trigger selection
		if (first_cap && sec_v) begin
			n.ev1 = 1'b1;
			if (!rev) begin
				n.first = s.cnt;
			end
		end
		if (first_cap && rev && prim_opp) begin
			n.first = s.cnt;
		end
		// Output pin
		if (!s.out_en) begin
			n.pin = 1'b0;
		end else if (mode == TCC_MODE_PPG) begin
			if (m1) begin
				n.pin = 1'b1;
			end else if (m2) begin
				n.pin = 1'b0;
			end
		end else if (m1 || m2 || edge_tog) begin
			n.pin = ~s.pin;
		end
	end

	// State register
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	// Outputs straight from state
	assign s_axi_awready_out = s.aw_rdy;
	assign s_axi_wready_out = s.w_rdy;
	assign s_axi_bresp_out = s.bresp;
	assign s_axi_bvalid_out = s.bvalid;
	assign s_axi_arready_out = s.ar_rdy;
	assign s_axi_rdata_out = s.rdata;
	assign s_axi_rresp_out = s.rresp;
	assign s_axi_rvalid_out = s.rvalid;
	assign toggle_output_pin_out = s.pin;
	assign first_match_event_out = s.ev1;
	assign second_match_event_out = s.ev2;

	// Checks
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!resetn_in);

	sequence s_ppg_end;
		mode == TCC_MODE_PPG && m1 && s.out_en;
	endsequence
	sequence s_ppg_start;
		s.cnt == CNT_ZERO && toggle_output_pin_out && first_match_event_out;
	endsequence

	a_count_read: assert property (s_axi_arvalid_in && s.ar_rdy && s_axi_araddr_in == OFF_CNT
		|=> s_axi_rvalid_out && s_axi_rdata_out[15:0] == $past(s.cnt))
		else $error("count read mismatch");
	a_free_first_match: assert property (mode == TCC_MODE_FREE && m1 && s.cnt != CNT_MAX
		|=> first_match_event_out && s.cnt == $past(s.cnt) + CNT_ONE)
		else $error("first match wrong");
	a_second_match_run: assert property (mode == TCC_MODE_FREE && m2 && s.cnt != CNT_MAX
		|=> second_match_event_out && s.cnt == $past(s.cnt) + CNT_ONE)
		else $error("second match wrong");
	a_first_capture: assert property (first_cap && !rev && sec_v
		|=> s.first == $past(s.cnt) && first_match_event_out)
		else $error("first capture wrong");
	a_second_capture: assert property (second_cap && prim_v
		|=> s.second == $past(s.cnt) && second_match_event_out)
		else $error("second capture wrong");
	a_wrap_set: assert property (mode == TCC_MODE_FREE && tick && s.cnt == CNT_MAX
		|=> s.wrap && s.cnt == CNT_ZERO)
		else $error("wrap not taken");
	a_wrap_hold: assert property (s.wrap && !(wcommit && s.aw_addr == OFF_MODE && s.w_strb[0])
		|=> s.wrap)
		else $error("wrap flag lost");
	a_edge_clear: assert property (edge_clr |=> s.cnt == CNT_ZERO)
		else $error("edge clear missed");
	a_ppg_restart: assert property (s_ppg_end |=> s_ppg_start)
		else $error("pulse period restart wrong");
	a_ppg_fall: assert property (mode == TCC_MODE_PPG && m2 && !m1 && s.out_en
		|=> !toggle_output_pin_out ##1 ($past(m1) || !toggle_output_pin_out))
		else $error("pulse end wrong");
	a_cap_pin_quiet: assert property (mode == TCC_MODE_FREE && first_cap && second_cap
		&& !edge_tog && s.out_en |=> $stable(toggle_output_pin_out))
		else $error("pin toggled while capturing");
	a_reverse_no_event: assert property (first_cap && rev && prim_opp && !sec_v
		|=> !first_match_event_out && s.first == $past(s.cnt))
		else $error("reverse capture wrong");

	// Counting, stop and count clock
	a_stop_cleared: assert property (!run
		|=> s.cnt == CNT_ZERO && !first_match_event_out && !second_match_event_out)
		else $error("stopped counter moved");
	a_free_count: assert property (mode == TCC_MODE_FREE && tick && s.cnt != CNT_MAX
		|=> s.cnt == $past(s.cnt) + CNT_ONE)
		else $error("free count step wrong");
	a_count_idle: assert property (mode == TCC_MODE_FREE && !tick
		|=> $stable(s.cnt))
		else $error("count moved without tick");

	// Output pin in the free-running, edge-clear and pulse generator modes
	a_match_toggle: assert property ((mode == TCC_MODE_FREE || mode == TCC_MODE_EDGE_CLR)
		&& s.out_en && (m1 || m2) |=> toggle_output_pin_out != $past(toggle_output_pin_out))
		else $error("match did not toggle pin");
	a_edge_toggle: assert property (edge_tog && s.out_en
		|=> toggle_output_pin_out != $past(toggle_output_pin_out))
		else $error("edge did not toggle pin");
	a_ppg_clear: assert property (mode == TCC_MODE_PPG && tick && s.cnt == s.first
		|=> s.cnt == CNT_ZERO)
		else $error("pulse period clear missed");
	a_ppg_steady: assert property (mode == TCC_MODE_PPG && s.out_en && !m1 && !m2
		|=> $stable(toggle_output_pin_out))
		else $error("pulse level moved between matches");

	// Capture routing
	a_free_cap_second: assert property (mode == TCC_MODE_FREE && !first_cap && second_cap
		&& prim_v |=> s.second == $past(s.cnt) && second_match_event_out)
		else $error("free capture into second wrong");
	a_second_quiet: assert property (second_cap && !prim_v
		&& !(wcommit && s.aw_addr == OFF_SECOND) |=> $stable(s.second) && !second_match_event_out)
		else $error("second captured without primary edge");
	a_first_quiet: assert property (first_cap && !rev && !sec_v
		&& !(wcommit && s.aw_addr == OFF_FIRST) |=> $stable(s.first) && !first_match_event_out)
		else $error("first captured without secondary edge");

	// Bus refusals while an answer stands
	a_write_refused: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
		else $error("write taken during response");
	a_read_refused: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
		else $error("read taken during response");
endmodule // tcc_timer
`default_nettype wire

/* verif/tcc_pin_model.sv */
// Model of the pulse sources on the capture pins and the load on the timer output
`timescale 1ns/1ps
`default_nettype none
module tcc_pin_model
	import tcc_pkg::*;
(
	// Clock
	input wire logic clk_in,
	// Timer output at the load
	input wire logic toggle_in,
	// Capture pin drivers
	output logic prim_out,
	output logic sec_out
);
	logic sec_busy;
	logic seen_out;
	// Both sources idle low
	initial begin
		prim_out = 1'b0;
		sec_out = 1'b0;
		sec_busy = 1'b0;
	end
	// One pulse, high then low, each well over two clocks
	task automatic pulse(input logic which, input int hi);
		@(posedge clk_in);
		sec_busy <= which;
		if (which) sec_out <= 1'b1;
		else prim_out <= 1'b1;
		repeat (hi) @(posedge clk_in);
		if (which) sec_out <= 1'b0;
		else prim_out <= 1'b0;
		repeat (8) @(posedge clk_in);
		sec_busy <= 1'b0;
	endtask
	// Load disregards the output while secondary edges are in use
	always @(posedge clk_in) begin
		if (!sec_busy) seen_out <= toggle_in;
	end
endmodule // tcc_pin_model
`default_nettype wire

/* verif/tb_top.sv */
// Self-checking bench for the capture/compare timer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_errors++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module tb_top
	import tcc_pkg::*;
;
	logic clk_in, resetn_in, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, prim, sec, pin, pin_q, ev1, ev2;
	logic [31:0] awaddr, wdata, araddr, rdata, v, u;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, r;
	int n_errors, tests_run, n_ev1, n_ev2, n_tog, hi, lo;
	tcc_timer dut (.clk_in(clk_in), .resetn_in(resetn_in), .s_axi_awaddr_in(awaddr),
		.s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
		.s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
		.s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
		.s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
		.s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
		.s_axi_rready_in(rready), .primary_capture_input_in(prim), .secondary_capture_input_in(sec),
		.toggle_output_pin_out(pin), .first_match_event_out(ev1), .second_match_event_out(ev2));
	tcc_pin_model pm (.clk_in(clk_in), .toggle_in(pin), .prim_out(prim), .sec_out(sec));
	// Clock
	initial begin
		clk_in = 1'b0;
		forever #20 clk_in = ~clk_in;
	end
	// Event and toggle monitor
	always @(posedge clk_in) begin
		pin_q <= pin;
		if (ev1 === 1'b1) n_ev1++;
		if (ev2 === 1'b1) n_ev2++;
		if (pin !== pin_q) n_tog++;
	end
	task automatic wrap_up();
		$display("Checks %0d errors %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic fail_to();
		n_errors++;
		$display("ERROR wait exp done got timeout");
		wrap_up();
	endtask
	task automatic clr_mon();
		@(negedge clk_in);
		n_ev1 = 0;
		n_ev2 = 0;
		n_tog = 0;
	endtask
	// Write with both channels offered together
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		int k;
		@(posedge clk_in);
		awaddr <= a; awvalid <= 1'b1; wdata <= d; wvalid <= 1'b1; bready <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(posedge clk_in);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) begin r = bresp; bready <= 1'b0; break; end
		end
		if (k == 50) fail_to();
	endtask
	task automatic rd(input logic [31:0] a, output logic [31:0] d);
		int k;
		@(posedge clk_in);
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(posedge clk_in);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) begin d = rdata; r = rresp; rready <= 1'b0; break; end
		end
		if (k == 50) fail_to();
	endtask
	task automatic wait_pin(input logic lvl, output int n);
		for (n = 1; n < 1000; n++) begin
			@(posedge clk_in);
			if (pin === lvl) return;
		end
		fail_to();
	endtask
	// Reset values, unmapped address, read-only counter
	task automatic t_reset();
		logic [31:0] offs [7] = '{OFF_MODE, OFF_ROLE, OFF_OUTC, OFF_PRESC, OFF_CNT, OFF_FIRST, OFF_SECOND};
		foreach (offs[k]) begin
			rd(offs[k], v);
			`CHK("reset_val", 32'h0000_0000, v)
		end
		rd(32'h0000_0040, v);
		`CHK("unmapped_rresp", RESP_SLVERR, r)
		wr(32'h0000_0040, 32'h0000_1234);
		`CHK("unmapped_bresp", RESP_SLVERR, r)
		wr(OFF_CNT, 32'h0000_1234);
		`CHK("cnt_wr_okay", RESP_OKAY, r)
		rd(OFF_CNT, v);
		`CHK("cnt_ro", 32'h0000_0000, v)
	endtask
	// Free-running with two compares
	task automatic t_compare();
		wr(OFF_OUTC, 32'h0000_0001);
		wr(OFF_FIRST, 32'h0000_0040);
		wr(OFF_SECOND, 32'h0000_0080);
		clr_mon();
		wr(OFF_MODE, 32'h0000_0004);
		repeat (200) @(posedge clk_in);
		rd(OFF_CNT, v);
		`CHK("cnt_no_clr", 1'b1, v[15:0] > 16'd200)
		`CHK("ev1_cnt", 1, n_ev1)
		`CHK("ev2_cnt", 1, n_ev2)
		`CHK("toggles", 2, n_tog)
		`CHK("load_seen", pin, pm.seen_out)
	endtask
	// Counting rate, wrap and flag clear
	task automatic t_free();
		rd(OFF_CNT, u);
		repeat (20) @(posedge clk_in);
		rd(OFF_CNT, v);
		`CHK("cnt_rate", 1'b1, (v[15:0] - u[15:0]) >= 16'd20 && (v[15:0] - u[15:0]) < 16'd40)
		repeat (65536 - int'(v[15:0]) + 8) @(posedge clk_in);
		rd(OFF_CNT, v);
		`CHK("cnt_wrapped", 1'b1, v[15:0] < 16'h0040)
		rd(OFF_MODE, v);
		`CHK("wrap_set", 32'h0000_0005, v)
		wr(OFF_MODE, 32'h0000_0004);
		rd(OFF_MODE, v);
		`CHK("wrap_clr", 32'h0000_0004, v)
	endtask
	// Both registers capturing in free-running mode
	task automatic t_capture();
		wr(OFF_MODE, 32'h0000_0000);
		wr(OFF_ROLE, 32'h0000_0005);
		wr(OFF_PRESC, 32'h0000_0050);
		wr(OFF_FIRST, 32'h0000_0000);
		wr(OFF_SECOND, 32'h0000_0000);
		clr_mon();
		wr(OFF_MODE, 32'h0000_0004);
		repeat (30) @(posedge clk_in);
		pm.pulse(1'b0, 4);
		rd(OFF_SECOND, v);
		rd(OFF_CNT, u);
		`CHK("second_cap", 1'b1, v != 0 && v < u)
		rd(OFF_FIRST, v);
		`CHK("first_idle", 32'h0000_0000, v)
		`CHK("no_toggle", 0, n_tog)
		`CHK("ev2_cap", 1, n_ev2)
		wr(OFF_MODE, 32'h0000_0006);
		pm.pulse(1'b1, 4);
		rd(OFF_FIRST, v);
		`CHK("first_cap", 1'b1, v != 0)
		`CHK("ev1_cap", 1, n_ev1)
		pm.pulse(1'b0, 4);
		`CHK("edge_toggle", 1, n_tog)
		wr(OFF_PRESC, 32'h0000_0060);
		rd(OFF_SECOND, u);
		pm.pulse(1'b0, 4);
		pm.pulse(1'b1, 4);
		rd(OFF_SECOND, v);
		`CHK("second_none", u, v)
		`CHK("ev1_sec_only", 2, n_ev1)
		`CHK("ev2_none", 2, n_ev2)
	endtask
	// Edge clear with reverse-phase capture
	task automatic t_edge_clr();
		wr(OFF_MODE, 32'h0000_0000);
		wr(OFF_ROLE, 32'h0000_0003);
		wr(OFF_SECOND, 32'h0000_FFF0);
		wr(OFF_PRESC, 32'h0000_0010);
		clr_mon();
		wr(OFF_MODE, 32'h0000_000A);
		repeat (300) @(posedge clk_in);
		pm.pulse(1'b0, 6);
		rd(OFF_CNT, v);
		`CHK("edge_clear", 1'b1, v[15:0] < 16'd30)
		rd(OFF_FIRST, v);
		`CHK("rev_cap", 1'b1, v >= 3 && v <= 9)
		`CHK("rev_no_ev1", 0, n_ev1)
		`CHK("edge_tog", 1, n_tog)
	endtask
	// Pulse generator, period 10 and high 4
	task automatic t_ppg();
		wr(OFF_MODE, 32'h0000_0000);
		wr(OFF_ROLE, 32'h0000_0000);
		wr(OFF_PRESC, 32'h0000_0000);
		wr(OFF_FIRST, 32'h0000_0009);
		wr(OFF_SECOND, 32'h0000_0003);
		wr(OFF_MODE, 32'h0000_000C);
		wait_pin(1'b1, hi);
		wait_pin(1'b0, hi);
		wait_pin(1'b1, lo);
		`CHK("ppg_high", 4, hi)
		`CHK("ppg_period", 10, hi + lo)
		rd(OFF_CNT, v);
		`CHK("ppg_cnt", 1'b1, v <= 9)
	endtask
	// Main sequence
	initial begin
		resetn_in = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, wdata, araddr} = '0;
		wstrb = 4'hF;
		pin_q = 1'b0;
		repeat (2) @(posedge clk_in);
		resetn_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		t_reset();
		t_compare();
		t_free();
		t_capture();
		t_edge_clr();
		t_ppg();
		wrap_up();
	end
endmodule // tb_top
`default_nettype wire
